// [verif/tb_top.sv]
// self-checking bench of the card presence check block
module tb_top
  import cpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ***************************************************************
  // signals
  // ***************************************************************
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic later_rev_in = 1'b0;
  logic meas_start_in = 1'b0;
  logic meas_end_in = 1'b0;
  cpc_sample_t sample_in = '0;
  logic [7:0] reg_rdata_out;
  logic sampling_active_out;
  logic full_drive_select_out;
  logic noise_filter_enable_out;
  logic detect_irq_status_out;
  int err_total = 0;
  int samples_checked = 0;
  int seed = 32'haaa6;

  cpc_detect_top u_cpc_detect_top (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .later_rev_in(later_rev_in),
    .meas_start_in(meas_start_in),
    .meas_end_in(meas_end_in),
    .sample_in(sample_in),
    .reg_rdata_out(reg_rdata_out),
    .sampling_active_out(sampling_active_out),
    .full_drive_select_out(full_drive_select_out),
    .noise_filter_enable_out(noise_filter_enable_out),
    .detect_irq_status_out(detect_irq_status_out)
  );

  initial begin
    forever #12.5 mclk_in = ~mclk_in;
  end

  // ***************************************************************
  // tasks and expectation functions
  // ***************************************************************
  task automatic chk(input string name, input logic [7:0] exp,
                     input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    @(negedge mclk_in);
    d = reg_rdata_out;
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a,
                        input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(name, exp, d);
  endtask

  // filtered or raw value after sample j
  function automatic logic [5:0] step(input logic filt, input int j,
                                      input logic [5:0] acc,
                                      input logic [5:0] s);
    logic [6:0] sum;
    sum = {1'b0, acc} + {1'b0, s} + 7'h01;
    if (!filt || j == 0)
      return s;
    return sum[6:1];
  endfunction

  function automatic logic viol(input logic [5:0] iv, qv, il, iu, ql,
                                qu);
    return (iv < il) || (iv > iu) || (qv < ql) || (qv > qu);
  endfunction

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #(25 * 40000);
    err_total++;
    $display("watchdog expired");
    end_of_test();
  end

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin : main
    logic [7:0] r3f, r40, r41, d, opt;
    logic [5:0] si[3], sq[3], fi, fq, iu;
    logic mute, seen, iun, qun, xirq;
    int n, cnt;
    repeat (16) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    // reset values and plain registers
    foreach (r3f[k]) rd_chk("reset", 8'h3A + 8'(k), 8'h00);
    foreach (si[k]) begin
      d = 8'($random(seed));
      wr(CPC_OFS_Q_LOWER + 8'(k), d);
      rd_chk("border reg", CPC_OFS_Q_LOWER + 8'(k), d);
    end
    wr(CPC_OFS_I_RESULT, 8'hFF);
    rd_chk("i result ro", CPC_OFS_I_RESULT, 8'h00);
    wr(CPC_OFS_Q_RESULT, 8'hFF);
    rd_chk("q result ro", CPC_OFS_Q_RESULT, 8'h40);
    rd_chk("unmapped", 8'h55, 8'h00);
    wr(CPC_OFS_OPTIONS, 8'hFF);
    rd_chk("options early rev", CPC_OFS_OPTIONS, 8'h00);
    chk("drive early rev", 8'h00, 8'(full_drive_select_out));
    $display("test registers done");
    @(posedge mclk_in);
    later_rev_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    wr(CPC_OFS_OPTIONS, 8'hFF);
    rd_chk("options later rev", CPC_OFS_OPTIONS, 8'h0C);
    chk("full drive out", 8'h01, 8'(full_drive_select_out));
    chk("filter out", 8'h01, 8'(noise_filter_enable_out));
    $display("test options done");
    // measurements, two boundary cases first
    for (int k = 0; k < 40; k++) begin
      r3f = 8'($random(seed));
      r40 = 8'($random(seed));
      r41 = 8'($random(seed));
      opt = 8'($random(seed)) & 8'h0C;
      n = 1 + ($unsigned($random(seed)) % 3);
      mute = ($random(seed) & 3) == 0;
      if (k < 2) begin
        r3f = 8'hA0;
        r40 = 8'h20;
        r41 = 8'h20;
        opt = 8'h00;
        n = 1;
        mute = 1'b0;
      end
      wr(CPC_OFS_Q_LOWER, r3f);
      wr(CPC_OFS_Q_UPPER, r40);
      wr(CPC_OFS_I_LOWER, r41);
      wr(CPC_OFS_OPTIONS, opt);
      @(negedge mclk_in);
      chk("full drive", 8'(opt[3]), 8'(full_drive_select_out));
      chk("filter", 8'(opt[2]), 8'(noise_filter_enable_out));
      iu = {r3f[7:6], r40[7:6], r41[7:6]};
      @(posedge mclk_in);
      meas_start_in <= 1'b1;
      @(posedge mclk_in);
      meas_start_in <= 1'b0;
      iun = 1'b0;
      qun = 1'b0;
      for (int j = 0; j < n; j++) begin
        si[j] = (k < 2) ? 6'h20 + 6'(k) : 6'($random(seed));
        sq[j] = (k < 2) ? 6'h20 : 6'($random(seed));
        if (j > 0 && si[j] != si[j-1]) iun = 1'b1;
        if (j > 0 && sq[j] != sq[j-1]) qun = 1'b1;
        fi = step(opt[2], j, fi, si[j]);
        fq = step(opt[2], j, fq, sq[j]);
        @(posedge mclk_in);
        sample_in <= '{valid: 1'b1, i_val: si[j], q_val: sq[j]};
        @(posedge mclk_in);
        sample_in.valid <= 1'b0;
      end
      if (mute) wr(CPC_OFS_Q_RESULT, 8'h40);
      @(posedge mclk_in);
      meas_end_in <= 1'b1;
      @(posedge mclk_in);
      meas_end_in <= 1'b0;
      seen = 1'b0;
      repeat (4) begin
        @(negedge mclk_in);
        seen |= detect_irq_status_out;
      end
      // any border, filtered or raw
      xirq = viol(fi, fq, r41[5:0], iu, r3f[5:0], r40[5:0]);
      chk("detect irq", 8'(xirq && !mute), 8'(seen));
      rd_chk("i value", CPC_OFS_I_RESULT, {2'b00, fi});
      rd_chk("q value", CPC_OFS_Q_RESULT, {1'b0, mute, fq});
      d = opt | {6'h00, qun, iun};
      rd_chk("flags", CPC_OFS_OPTIONS, d);
    end
    $display("test measurements done");
    // sampling window closes by itself
    @(posedge mclk_in);
    meas_start_in <= 1'b1;
    @(posedge mclk_in);
    meas_start_in <= 1'b0;
    cnt = 0;
    repeat (200) begin
      @(negedge mclk_in);
      if (sampling_active_out === 1'b1) cnt++;
    end
    chk("window cycles", 8'(CPC_SAMPLE_MAX_CYC), 8'(cnt));
    $display("test window done");
    end_of_test();
  end
endmodule

// [verilog/cpc_border_cmp.sv]
// window comparison of one channel value against its two borders
module cpc_border_cmp
  import cpc_pkg::*;
(
  input wire cpc_val_t value_in,
  input wire cpc_val_t lower_in,
  input wire cpc_val_t upper_in,
  output logic below_out,
  output logic above_out
);

  // unsigned six bit compares
  assign below_out = value_in < lower_in;
  assign above_out = value_in > upper_in;

endmodule

// [verilog/cpc_chan_filter.sv]
// noise filter and instability tracker for one measurement channel
module cpc_chan_filter
  import cpc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic clear_in,
  input wire logic valid_in,
  input wire cpc_val_t sample_in,
  output cpc_val_t filt_out,
  output cpc_val_t raw_out,
  output logic unstable_out
);

  logic seen_q, seen_d;
  logic unst_q, unst_d;
  cpc_val_t raw_q, raw_d;
  cpc_val_t filt_q, filt_d;
  logic [6:0] sum;

  // *****************************************************************
  // running average of the samples and change detection
  // *****************************************************************
  always_comb begin
    seen_d = seen_q;
    unst_d = unst_q;
    raw_d = raw_q;
    filt_d = filt_q;
    sum = 7'(filt_q) + 7'(sample_in) + 7'h01;
    if (clear_in) begin
      seen_d = 1'b0;
      unst_d = 1'b0;
    end else if (valid_in) begin
      raw_d = sample_in;
      seen_d = 1'b1;
      // averaging smooths single noisy samples
      filt_d = seen_q ? sum[6:1] : sample_in;
      // any change during the window marks instability
      unst_d = unst_q | (seen_q & (sample_in != raw_q));
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      seen_q <= 1'b0;
      unst_q <= 1'b0;
      raw_q <= CPC_RESULT_RST;
      filt_q <= CPC_RESULT_RST;
    end else begin
      seen_q <= seen_d;
      unst_q <= unst_d;
      raw_q <= raw_d;
      filt_q <= filt_d;
    end
  end

  assign filt_out = filt_q;
  assign raw_out = raw_q;
  assign unstable_out = unst_q;

endmodule

// [verilog/cpc_detect_top.sv]
// card presence check: borders, results, options and detection decision
module cpc_detect_top
  import cpc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic later_rev_in,
  input wire logic meas_start_in,
  input wire logic meas_end_in,
  input wire cpc_sample_t sample_in,
  output logic [7:0] reg_rdata_out,
  output logic sampling_active_out,
  output logic full_drive_select_out,
  output logic noise_filter_enable_out,
  output logic detect_irq_status_out
);

  // *****************************************************************
  // revision strap synchroniser
  // *****************************************************************
  logic rev_meta_q;
  logic rev_sync_q;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rev_meta_q <= 1'b0;
      rev_sync_q <= 1'b0;
    end else begin
      rev_meta_q <= later_rev_in;
      rev_sync_q <= rev_meta_q;
    end
  end

  // *****************************************************************
  // configuration registers
  // *****************************************************************
  cpc_borders_t brd_q, brd_d;
  logic full_drive_q, full_drive_d;
  logic filter_en_q, filter_en_d;
  logic supp_q, supp_d;
  logic [7:0] w;

  always_comb begin
    brd_d = brd_q;
    full_drive_d = full_drive_q;
    filter_en_d = filter_en_q;
    supp_d = supp_q;
    w = reg_wdata_in;
    // a new detection procedure lifts the mute
    if (meas_start_in) begin
      supp_d = 1'b0;
    end
    if (reg_wr_in) begin
      case (reg_addr_in)
        CPC_OFS_OPTIONS: begin
          // absent on the earlier revision
          if (rev_sync_q) begin
            full_drive_d = w[CPC_BIT_FULL_DRIVE];
            filter_en_d = w[CPC_BIT_FILTER];
          end
        end
        CPC_OFS_Q_LOWER: begin
          brd_d.i_upper[5:4] = w[CPC_IUP_FLD_MSB:CPC_IUP_FLD_LSB];
          brd_d.q_lower = w[CPC_VAL_MSB:0];
        end
        CPC_OFS_Q_UPPER: begin
          brd_d.i_upper[3:2] = w[CPC_IUP_FLD_MSB:CPC_IUP_FLD_LSB];
          brd_d.q_upper = w[CPC_VAL_MSB:0];
        end
        CPC_OFS_I_LOWER: begin
          brd_d.i_upper[1:0] = w[CPC_IUP_FLD_MSB:CPC_IUP_FLD_LSB];
          brd_d.i_lower = w[CPC_VAL_MSB:0];
        end
        CPC_OFS_Q_RESULT: begin
          // write beats the start clear in the same cycle
          supp_d = w[CPC_BIT_SUPPRESS];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      brd_q <= '{CPC_BORDER_RST, CPC_BORDER_RST, CPC_BORDER_RST,
                 CPC_BORDER_RST};
      full_drive_q <= CPC_OPT_BIT_RST;
      filter_en_q <= CPC_OPT_BIT_RST;
      supp_q <= CPC_SUPPRESS_RST;
    end else begin
      brd_q <= brd_d;
      full_drive_q <= full_drive_d;
      filter_en_q <= filter_en_d;
      supp_q <= supp_d;
    end
  end

  assign full_drive_select_out = full_drive_q;
  assign noise_filter_enable_out = filter_en_q;

  // *****************************************************************
  // measurement sequence
  // *****************************************************************
  cpc_state_t st_q, st_d;
  logic [7:0] cnt_q, cnt_d;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    case (st_q)
      CPC_IDLE: begin
        if (meas_start_in) begin
          st_d = CPC_SAMPLE;
          cnt_d = 8'h00;
        end
      end
      CPC_SAMPLE: begin
        cnt_d = cnt_q + 8'h01;
        // sampling window closes no later than 4.72us
        if (meas_end_in || cnt_q == CPC_SAMPLE_LAST) begin
          st_d = CPC_EVAL;
        end
      end
      CPC_EVAL: begin
        st_d = CPC_IDLE;
      end
      default: begin
        st_d = CPC_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= CPC_IDLE;
      cnt_q <= 8'h00;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  assign sampling_active_out = st_q == CPC_SAMPLE;

  // *****************************************************************
  // channel filters and border compares
  // *****************************************************************
  logic take;
  cpc_val_t i_filt, i_raw, q_filt, q_raw;
  cpc_val_t i_sel, q_sel;
  logic i_unst, q_unst;
  logic i_below, i_above, q_below, q_above;
  logic viol;

  assign take = sample_in.valid && st_q == CPC_SAMPLE;

  cpc_chan_filter u_i_filter (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .clear_in(meas_start_in),
    .valid_in(take),
    .sample_in(sample_in.i_val),
    .filt_out(i_filt),
    .raw_out(i_raw),
    .unstable_out(i_unst)
  );

  cpc_chan_filter u_q_filter (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .clear_in(meas_start_in),
    .valid_in(take),
    .sample_in(sample_in.q_val),
    .filt_out(q_filt),
    .raw_out(q_raw),
    .unstable_out(q_unst)
  );

  // filtered or raw values feed the decision
  assign i_sel = filter_en_q ? i_filt : i_raw;
  assign q_sel = filter_en_q ? q_filt : q_raw;

  cpc_border_cmp u_i_cmp (
    .value_in(i_sel),
    .lower_in(brd_q.i_lower),
    .upper_in(brd_q.i_upper),
    .below_out(i_below),
    .above_out(i_above)
  );

  cpc_border_cmp u_q_cmp (
    .value_in(q_sel),
    .lower_in(brd_q.q_lower),
    .upper_in(brd_q.q_upper),
    .below_out(q_below),
    .above_out(q_above)
  );

  // any violated border counts
  assign viol = i_below | i_above | q_below | q_above;

  // *****************************************************************
  // results and detection status
  // *****************************************************************
  cpc_val_t res_i_q, res_i_d, res_q_q, res_q_d;
  logic unst_i_q, unst_i_d, unst_q_q, unst_q_d;
  logic irq_q, irq_d;

  always_comb begin
    res_i_d = res_i_q;
    res_q_d = res_q_q;
    unst_i_d = unst_i_q;
    unst_q_d = unst_q_q;
    irq_d = 1'b0;
    if (st_q == CPC_EVAL) begin
      res_i_d = i_sel;
      res_q_d = q_sel;
      unst_i_d = i_unst;
      unst_q_d = q_unst;
      // one pulse sets the detection status bit
      irq_d = viol & ~supp_q;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      res_i_q <= CPC_RESULT_RST;
      res_q_q <= CPC_RESULT_RST;
      unst_i_q <= 1'b0;
      unst_q_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      res_i_q <= res_i_d;
      res_q_q <= res_q_d;
      unst_i_q <= unst_i_d;
      unst_q_q <= unst_q_d;
      irq_q <= irq_d;
    end
  end

  assign detect_irq_status_out = irq_q;

  // *****************************************************************
  // register read port
  // *****************************************************************
  logic [7:0] rd_q, rd_d;

  always_comb begin
    rd_d = 8'h00;
    if (reg_rd_in) begin
      case (reg_addr_in)
        CPC_OFS_OPTIONS: begin
          if (rev_sync_q) begin
            rd_d[CPC_BIT_FULL_DRIVE] = full_drive_q;
            rd_d[CPC_BIT_FILTER] = filter_en_q;
            rd_d[CPC_BIT_Q_UNSTABLE] = unst_q_q;
            rd_d[CPC_BIT_I_UNSTABLE] = unst_i_q;
          end
        end
        CPC_OFS_Q_LOWER: begin
          rd_d = {brd_q.i_upper[5:4], brd_q.q_lower};
        end
        CPC_OFS_Q_UPPER: begin
          rd_d = {brd_q.i_upper[3:2], brd_q.q_upper};
        end
        CPC_OFS_I_LOWER: begin
          rd_d = {brd_q.i_upper[1:0], brd_q.i_lower};
        end
        CPC_OFS_I_RESULT: begin
          rd_d = {2'h0, res_i_q};
        end
        CPC_OFS_Q_RESULT: begin
          rd_d = {1'b0, supp_q, res_q_q};
        end
        default: begin
          rd_d = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_q <= 8'h00;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign reg_rdata_out = rd_q;

  // *****************************************************************
  // assertions
  // *****************************************************************
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  chk_irq_has_cause: assert property (
    detect_irq_status_out |->
      $past(st_q == CPC_EVAL) && $past(viol) && !$past(supp_q))
    else $error("detection pulse without a violated border");

  chk_irq_muted: assert property (
    st_q == CPC_EVAL && supp_q |=> !detect_irq_status_out)
    else $error("detection pulse while muted");

  chk_mute_lifted: assert property (
    meas_start_in && !(reg_wr_in && reg_addr_in == CPC_OFS_Q_RESULT)
      |=> !supp_q)
    else $error("mute not lifted at detection start");

  chk_i_upper_trip: assert property (
    st_q == CPC_EVAL && !supp_q && i_sel > brd_q.i_upper
      |=> detect_irq_status_out)
    else $error("I above upper border missed");

  chk_i_lower_trip: assert property (
    st_q == CPC_EVAL && !supp_q && i_sel < brd_q.i_lower
      |=> detect_irq_status_out)
    else $error("I below lower border missed");

  chk_q_upper_trip: assert property (
    st_q == CPC_EVAL && !supp_q && q_sel > brd_q.q_upper
      |=> detect_irq_status_out)
    else $error("Q above upper border missed");

  chk_iup_mid_bits: assert property (
    reg_rd_in && reg_addr_in == CPC_OFS_Q_UPPER
      |=> reg_rdata_out[7:6] == $past(brd_q.i_upper[3:2]))
    else $error("upper I border bits 3,2 misplaced");

  chk_old_rev_gap: assert property (
    reg_rd_in && reg_addr_in == CPC_OFS_OPTIONS && !rev_sync_q
      |=> reg_rdata_out == 8'h00)
    else $error("options visible on earlier revision");

  chk_window_bound: assert property (
    $rose(sampling_active_out) |-> ##[1:188] !sampling_active_out)
    else $error("sampling window too long");

  chk_result_ro: assert property (
    reg_wr_in && reg_addr_in == CPC_OFS_I_RESULT && st_q != CPC_EVAL
      |=> $stable(res_i_q))
    else $error("I result changed by a write");

  cov_detect: cover property ($rose(detect_irq_status_out));
  cov_muted_hit: cover property (st_q == CPC_EVAL && supp_q && viol);
  cov_window_cap: cover property (st_q == CPC_SAMPLE &&
    cnt_q == CPC_SAMPLE_LAST);
  cov_unstable: cover property (st_q == CPC_EVAL && filter_en_q && i_unst);

endmodule

// [verilog/cpc_pkg.sv]
// constants, types and behaviour list of the card presence check block
// *****************************************************************
// Behaviour
// - upper I border bits 3,2 in 0x40[7:6]
// - 0x40[5:0] upper Q border, above raises
// - upper I border bits 1,0 in 0x41[7:6]
// - I value above upper I border raises
// - 0x41[5:0] lower I border, below raises
// - last I value read-only in 0x42[5:0]
// - last Q value read-only in 0x43[5:0]
// - 0x43 bit 6 mutes interrupt until next start
// - options register only on later revision
// - options bit 3 selects full transmitter drive
// - options bit 2 uses filtered I/Q values
// - filtered sampling window at most 4.72us
// - options bit 1 flags Q value changing
// - options bit 0 flags I value changing
// - upper I border bits 5,4 in 0x3F[7:6]
// - 0x3F[5:0] lower Q border
// - detection raises the detection status bit
// *****************************************************************
package cpc_pkg;

  // *****************************************************************
  // register offsets
  // *****************************************************************
  localparam logic [7:0] CPC_OFS_OPTIONS = 8'h3A;
  localparam logic [7:0] CPC_OFS_Q_LOWER = 8'h3F;
  localparam logic [7:0] CPC_OFS_Q_UPPER = 8'h40;
  localparam logic [7:0] CPC_OFS_I_LOWER = 8'h41;
  localparam logic [7:0] CPC_OFS_I_RESULT = 8'h42;
  localparam logic [7:0] CPC_OFS_Q_RESULT = 8'h43;

  // *****************************************************************
  // field positions
  // *****************************************************************
  localparam int CPC_BIT_FULL_DRIVE = 3;
  localparam int CPC_BIT_FILTER = 2;
  localparam int CPC_BIT_Q_UNSTABLE = 1;
  localparam int CPC_BIT_I_UNSTABLE = 0;
  localparam int CPC_BIT_SUPPRESS = 6;
  localparam int CPC_IUP_FLD_MSB = 7;
  localparam int CPC_IUP_FLD_LSB = 6;
  localparam int CPC_VAL_MSB = 5;

  // *****************************************************************
  // reset values
  // *****************************************************************
  localparam logic [5:0] CPC_BORDER_RST = 6'h00;
  localparam logic [5:0] CPC_RESULT_RST = 6'h00;
  localparam logic CPC_OPT_BIT_RST = 1'h0;
  localparam logic CPC_SUPPRESS_RST = 1'h0;

  // *****************************************************************
  // timing
  // *****************************************************************
  localparam int CPC_CLK_MHZ = 40;
  localparam int CPC_SAMPLE_MAX_NS = 4720;
  localparam int CPC_SAMPLE_MAX_CYC = (CPC_SAMPLE_MAX_NS * CPC_CLK_MHZ) / 1000;
  localparam logic [7:0] CPC_SAMPLE_LAST = 8'(CPC_SAMPLE_MAX_CYC - 1);

  // *****************************************************************
  // types
  // *****************************************************************
  typedef logic [5:0] cpc_val_t;

  typedef struct packed {
    logic valid;
    cpc_val_t i_val;
    cpc_val_t q_val;
  } cpc_sample_t;

  typedef struct packed {
    cpc_val_t i_lower;
    cpc_val_t i_upper;
    cpc_val_t q_lower;
    cpc_val_t q_upper;
  } cpc_borders_t;

  typedef enum logic [1:0] {
    CPC_IDLE,
    CPC_SAMPLE,
    CPC_EVAL
  } cpc_state_t;

endpackage
